// ==== hdl/fpl_edge_det.sv ====
// Press detector: one-cycle pulse on each new press of a button.
// Assumes button levels synchronous to the clock, active high.
`timescale 1ns/100ps
module fpl_edge_det
#(
  parameter int unsigned WIDTH = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Levels in, rising edge pulses out
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] last;

  // One detector per input
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_edge
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          last[i] <= 1'b0;
          rise[i] <= 1'b0;
        end
        else
        begin
          last[i] <= level[i];
          rise[i] <= level[i] & ~last[i];
        end
      end
    end
  endgenerate

endmodule : fpl_edge_det

// ==== hdl/fpl_front_panel.sv ====
// Front panel power and LED controller top level.
// Assumes all inputs synchronous to clock, buttons active high.
//
// Functional notes
// - Power press becomes chipset request, never supply.
// - Off: button or wake edge starts power-up.
// - Power-up drives power-good then releases reset.
// - Chipset off state drops supply power-on.
// - Unserviced off request forces off within 4-5s.
// - Reset press forwarded to chipset as request.
// - Identify press toggles chassis ID LED.
// - ID LED holds until next press or command.
// - Power LED follows DC and ACPI state.
// - Status LED shows only most severe fault.
// - Any amber fault suppresses green indication.
// - Own faults merged with other controllers' faults.
// - Sensor contributions track current sensor state.
// - Status LED state kept through DC-off or S5.
// - Green/blink/amber-blink/amber/off status encoding.
// - Degraded sources raise the degraded state.
// - Non-fatal sources raise the non-fatal state.
// - Fatal sources raise the fatal state.
// - ID sources unprioritised; command identify blinks.
`timescale 1ns/100ps
module fpl_front_panel
  import fpl_pkg::*;
#(
  parameter int unsigned FAILSAFE_CYCLES = FAILSAFE_CYC,
  parameter int unsigned PWROK_CYCLES = PWROK_WAIT_CYC,
  parameter int unsigned RESET_CYCLES = RESET_HOLD_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Front panel buttons, high while pressed
  input wire logic powerButton,
  input wire logic resetButton,
  input wire logic identifyButton,
  // Chipset side
  input wire logic chipsetWake,
  input wire logic [1:0] chipsetAcpiState,
  input wire logic acpiEnabled,
  input wire logic firmwareAck,
  output logic powerButtonReq,
  output logic resetButtonReq,
  // Power supply side
  input wire logic supplyPowerGood,
  output logic supply_power_on,
  output logic platformPowerGood,
  output logic platformReset,
  // Identify commands: set blink/off from management firmware
  input wire logic identifyCmdValid,
  input wire logic identifyCmdOn,
  // Locally detected degraded sources
  input wire logic redundancyLost,
  input wire logic cpuDisabled,
  input wire logic fanFailed,
  input wire logic nonCriticalCrossed,
  input wire logic batteryFailed,
  input wire logic supplyPredictive,
  // Locally detected non-fatal sources
  input wire logic criticalCrossed,
  input wire logic regulator_hot,
  input wire logic fansBelowMinimum,
  // Locally detected fatal sources
  input wire logic cpu_catastrophic_error,
  input wire logic cpu_thermal_trip,
  input wire logic cpu1Missing,
  input wire logic supplyCountLow,
  // Severity from other controllers and firmware fault command
  input wire logic [1:0] hotSwapSeverity,
  input wire logic [1:0] firmwareSeverity,
  // LEDs
  output logic powerLed,
  output logic identifyLed,
  output logic statusGreenLed,
  output logic statusAmberLed,
  // State view
  output logic [2:0] powerState
);

  // ----------------------------------------------------------------
  // Shared pieces
  // ----------------------------------------------------------------
  logic blink;
  logic [2:0] press;
  logic wakeRise;
  logic [31:0] timer;
  fpl_pwr_t state;
  fpl_pwr_t next_state;
  logic offPending;
  logic [31:0] offTimer;
  logic idOn;
  logic idBlink;
  fpl_sev_t severity;
  fpl_sev_t next_severity;
  logic mainOn;

  // Single blink source keeps every LED in phase
  fpl_pulse_div #(
    .HALF_CYC(BLINK_CYCLES)
  ) u_div (
    .clock(clock),
    .rst(rst),
    .blink(blink)
  );

  // Press edges: power, reset, identify, and chipset wake
  fpl_edge_det #(
    .WIDTH(4)
  ) u_edge (
    .clock(clock),
    .rst(rst),
    .level({chipsetWake, identifyButton, resetButton, powerButton}),
    .rise({wakeRise, press})
  );

  // Highest of two severities
  function automatic fpl_sev_t sev_max(input fpl_sev_t a,
                                       input fpl_sev_t b);
    sev_max = (a > b) ? a : b;
  endfunction : sev_max

  // ----------------------------------------------------------------
  // Button forwarding
  // ----------------------------------------------------------------

  // Presses go to the chipset as requests, never to the supply
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      powerButtonReq <= 1'b0;
      resetButtonReq <= 1'b0;
    end
    else
    begin
      powerButtonReq <= press[0] && (state == PS_ON);
      resetButtonReq <= press[1] && (state == PS_ON);
    end
  end

  // ----------------------------------------------------------------
  // Fail-safe off timer
  // ----------------------------------------------------------------

  // Armed by an off request; cleared once firmware services it
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      offPending <= 1'b0;
      offTimer <= 32'h0000_0000;
    end
    else if (state != PS_ON)
    begin
      offPending <= 1'b0;
      offTimer <= 32'h0000_0000;
    end
    else if (press[0])
    begin
      offPending <= 1'b1;
      offTimer <= 32'h0000_0000;
    end
    else if (offPending && firmwareAck)
    begin
      offPending <= 1'b0;
    end
    else if (offPending)
    begin
      offTimer <= offTimer + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Power sequencer
  // ----------------------------------------------------------------

  // Next state of the sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      PS_OFF:
      begin
        if (press[0] || wakeRise)
        begin
          next_state = PS_WAIT_GOOD;
        end
      end
      PS_WAIT_GOOD:
      begin
        if (supplyPowerGood && timer >= PWROK_CYCLES - 1)
        begin
          next_state = PS_RESET;
        end
      end
      PS_RESET:
      begin
        if (timer >= RESET_CYCLES - 1)
        begin
          next_state = PS_ON;
        end
      end
      PS_ON:
      begin
        if (acpiEnabled && chipsetAcpiState == ACPI_S5)
        begin
          next_state = PS_OFF;
        end
        else if (offPending && offTimer >= FAILSAFE_CYCLES - 1)
        begin
          next_state = PS_FAILSAFE;
        end
      end
      PS_FAILSAFE:
      begin
        next_state = PS_OFF;
      end
      default:
      begin
        next_state = PS_OFF;
      end
    endcase
  end

  // State register and step timer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= PS_OFF;
      timer <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
      begin
        timer <= 32'h0000_0000;
      end
      else
      begin
        timer <= timer + 32'h0000_0001;
      end
    end
  end

  // Supply enable, power-good and reset outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      supply_power_on <= 1'b0;
      platformPowerGood <= 1'b0;
      platformReset <= 1'b1;
      powerState <= PS_OFF;
    end
    else
    begin
      supply_power_on <= (next_state == PS_WAIT_GOOD) ||
                         (next_state == PS_RESET) ||
                         (next_state == PS_ON);
      platformPowerGood <= (next_state == PS_RESET) ||
                           (next_state == PS_ON);
      platformReset <= (next_state != PS_ON);
      powerState <= next_state;
    end
  end

  assign mainOn = (state == PS_ON);

  // ----------------------------------------------------------------
  // Power LED
  // ----------------------------------------------------------------

  // Off when DC off, S5 or unknown code, blink in S1, solid otherwise
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      powerLed <= 1'b0;
    end
    else if (!mainOn)
    begin
      powerLed <= 1'b0;
    end
    else if (!acpiEnabled)
    begin
      powerLed <= 1'b1;
    end
    else
    begin
      case (chipsetAcpiState)
        ACPI_S0: powerLed <= 1'b1;
        ACPI_S1: powerLed <= blink;
        ACPI_S5: powerLed <= 1'b0;
        default: powerLed <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Chassis identify LED
  // ----------------------------------------------------------------

  // Latest source wins: button toggles solid, command sets blink/off
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      idOn <= 1'b0;
      idBlink <= 1'b0;
    end
    else if (press[2])
    begin
      idOn <= ~(idOn && !idBlink);
      idBlink <= 1'b0;
    end
    else if (identifyCmdValid)
    begin
      idOn <= identifyCmdOn;
      idBlink <= identifyCmdOn;
    end
  end

  // Drive the identify LED
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      identifyLed <= 1'b0;
    end
    else
    begin
      identifyLed <= idOn && (!idBlink || blink);
    end
  end

  // ----------------------------------------------------------------
  // System status LED
  // ----------------------------------------------------------------

  // Merge live sources into one worst severity
  always_comb
  begin
    next_severity = SEV_OK;
    if (redundancyLost || cpuDisabled || fanFailed ||
        nonCriticalCrossed || batteryFailed || supplyPredictive)
    begin
      next_severity = SEV_DEGRADED;
    end
    if (criticalCrossed || regulator_hot || fansBelowMinimum)
    begin
      next_severity = SEV_NONFATAL;
    end
    if (cpu_catastrophic_error || cpu_thermal_trip || cpu1Missing ||
        (mainOn && !supplyPowerGood) || supplyCountLow)
    begin
      next_severity = SEV_FATAL;
    end
    next_severity = sev_max(next_severity,
                            fpl_sev_t'(hotSwapSeverity));
    next_severity = sev_max(next_severity,
                            fpl_sev_t'(firmwareSeverity));
  end

  // Track sensors while on; freeze across DC-off and S5
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      severity <= SEV_OK;
    end
    else if (mainOn)
    begin
      severity <= next_severity;
    end
  end

  // Encode severity onto the bicolour LED
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      statusGreenLed <= 1'b0;
      statusAmberLed <= 1'b0;
    end
    else if (!mainOn)
    begin
      statusGreenLed <= 1'b0;
      statusAmberLed <= 1'b0;
    end
    else
    begin
      case (severity)
        SEV_OK:
        begin
          statusGreenLed <= 1'b1;
          statusAmberLed <= 1'b0;
        end
        SEV_DEGRADED:
        begin
          statusGreenLed <= blink;
          statusAmberLed <= 1'b0;
        end
        SEV_NONFATAL:
        begin
          statusGreenLed <= 1'b0;
          statusAmberLed <= blink;
        end
        default:
        begin
          statusGreenLed <= 1'b0;
          statusAmberLed <= 1'b1;
        end
      endcase
    end
  end

endmodule : fpl_front_panel

// ==== hdl/fpl_pkg.sv ====
// Package for the front panel power and LED controller.
// Assumes a 50 MHz system clock on standby power.
package fpl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BLINK_HZ = 1;
  // Half period of the shared blink, in cycles
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  // Fail-safe off window: at least 4 s, below 5 s; 4.5 s is taken
  localparam int unsigned FAILSAFE_MS = 4500;
  localparam int unsigned FAILSAFE_CYC = (CLK_HZ / 1000) * FAILSAFE_MS;
  // Power-up sequence steps
  localparam int unsigned PWROK_WAIT_MS = 100;
  localparam int unsigned PWROK_WAIT_CYC = (CLK_HZ / 1000) * PWROK_WAIT_MS;
  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned RESET_HOLD_CYC =
    (CLK_HZ / 1000000) * RESET_HOLD_US;

  // ----------------------------------------------------------------
  // Chipset ACPI state codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACPI_S0 = 2'h0;
  localparam logic [1:0] ACPI_S1 = 2'h1;
  localparam logic [1:0] ACPI_S5 = 2'h3;

  // ----------------------------------------------------------------
  // Status LED severity, low to high
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEV_OK = 2'b00,
    SEV_DEGRADED = 2'b01,
    SEV_NONFATAL = 2'b10,
    SEV_FATAL = 2'b11
  } fpl_sev_t;

  // Power sequencer states
  typedef enum logic [2:0]
  {
    PS_OFF = 3'b000,
    PS_WAIT_GOOD = 3'b001,
    PS_RESET = 3'b010,
    PS_ON = 3'b011,
    PS_FAILSAFE = 3'b100
  } fpl_pwr_t;

endpackage : fpl_pkg

// ==== hdl/fpl_pulse_div.sv ====
// Shared blink divider: square wave output only.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/100ps
module fpl_pulse_div
  import fpl_pkg::*;
#(
  parameter int unsigned HALF_CYC = BLINK_HALF_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Blink output, about 50 percent duty
  output logic blink
);

  logic [31:0] count;

  // Count half periods and flip the blink level
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count <= 32'h0000_0000;
      blink <= 1'b0;
    end
    else if (count >= HALF_CYC - 1)
    begin
      count <= 32'h0000_0000;
      blink <= ~blink;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule : fpl_pulse_div

// ==== testbench/fpl_chipset_model.sv ====
// Chipset power state machines and power supply behind the controller.
// Assumes the bench picks whether firmware answers and sleep entry.
`timescale 1ns/100ps
module fpl_chipset_model
  import fpl_pkg::*;
#(
  parameter int unsigned GOOD_DLY = 6
)
(
  // Clock and reset
  input wire logic clock, rst,
  // Bench controls
  input wire logic honour, sleep,
  // Controller side
  input wire logic supply_power_on, powerButtonReq,
  output logic supplyPowerGood,
  output logic [1:0] chipsetAcpiState
);
  logic [7:0] goodCnt;
  logic offReq;
  // Supply good lags power-on and drops at once
  always_ff @(posedge clock)
  begin
    if (rst || !supply_power_on)
      goodCnt <= '0;
    else if (goodCnt != 8'hff)
      goodCnt <= goodCnt + 8'h01;
  end
  assign supplyPowerGood = (goodCnt >= GOOD_DLY);
  // Firmware answers a forwarded press by asking for the off state
  always_ff @(posedge clock)
  begin
    if (rst || !supply_power_on)
      offReq <= 1'b0;
    else if (powerButtonReq && honour)
      offReq <= 1'b1;
  end
  // Sleep state code seen by the controller
  always_comb
  begin
    if (!supplyPowerGood || offReq)
      chipsetAcpiState = ACPI_S5;
    else if (sleep)
      chipsetAcpiState = ACPI_S1;
    else
      chipsetAcpiState = ACPI_S0;
  end
endmodule : fpl_chipset_model

// ==== testbench/fpl_front_panel_properties.sv ====
// Port assertions for the front panel power and LED controller.
// Assumes a bind from the bench, which passes the fail-safe count.
`timescale 1ns/100ps
module fpl_front_panel_properties
  import fpl_pkg::*;
#(
  parameter int unsigned FAILSAFE_CYCLES = 50
)
(
  // Clock, reset and inputs
  input wire logic clock, rst, powerButton, resetButton, chipsetWake,
  input wire logic acpiEnabled, cpu_catastrophic_error,
  input wire logic [1:0] chipsetAcpiState,
  // Outputs watched
  input wire logic powerButtonReq, resetButtonReq, supply_power_on,
  input wire logic platformPowerGood, platformReset, powerLed,
  input wire logic statusGreenLed, statusAmberLed,
  input wire logic [2:0] powerState
);
  localparam int FS_LO = FAILSAFE_CYCLES - 4;
  localparam int FS_HI = FAILSAFE_CYCLES + 3;
  logic [31:0] sinceReq;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Cycles since the last power request, saturating
  always_ff @(posedge clock)
  begin
    if (rst || powerButtonReq)
      sinceReq <= '0;
    else if (sinceReq != 32'hffff_ffff)
      sinceReq <= sinceReq + 32'h0000_0001;
  end
  // Reset held through the power-good step, then released into on
  sequence resetHold;
    platformReset [*3] ##[1:3] (!platformReset && powerState == 3'h3);
  endsequence
  sequence offDrop;
    !supply_power_on && !platformPowerGood && platformReset;
  endsequence
  chk_press_fwd: assert property (
    (powerState == 3'h3 && $rose(powerButton)) |-> ##[1:3] powerButtonReq)
    else $error("power press not forwarded");
  chk_reset_fwd: assert property (
    (powerState == 3'h3 && $rose(resetButton)) |-> ##[1:3] resetButtonReq)
    else $error("reset press not forwarded");
  chk_req_only_on: assert property (
    (powerButtonReq || resetButtonReq) |-> $past(powerState) == 3'h3)
    else $error("request outside on state");
  chk_wake_start: assert property (
    (powerState == 3'h0 && $rose(chipsetWake))
      |-> ##[1:3] (supply_power_on && powerState == 3'h1))
    else $error("wake did not start power-up");
  chk_seq_reset: assert property (
    $rose(platformPowerGood) |-> resetHold)
    else $error("reset release out of sequence");
  chk_s5_off: assert property (
    (powerState == 3'h3 && acpiEnabled && chipsetAcpiState == ACPI_S5)
      |-> ##[1:2] offDrop)
    else $error("off state did not drop supply");
  chk_failsafe_time: assert property (
    $rose(powerState == 3'h4) |-> sinceReq >= FS_LO && sinceReq <= FS_HI)
    else $error("fail-safe off at wrong time");
  chk_amber_wins: assert property (
    statusAmberLed |-> !statusGreenLed)
    else $error("green lit with amber");
  chk_fatal_shown: assert property (
    (powerState == 3'h3 && cpu_catastrophic_error) [*3] |-> statusAmberLed)
    else $error("fatal fault not amber");
  chk_pled_off: assert property (
    (powerState == 3'h0) [*3] |-> !powerLed)
    else $error("power LED lit while off");
  chk_pled_solid: assert property (
    (powerState == 3'h3 && !acpiEnabled) [*3] |-> powerLed)
    else $error("power LED dark while on");
endmodule : fpl_front_panel_properties

// ==== testbench/tb.sv ====
// Self-checking bench for the front panel controller.
// Assumes short count parameters; inputs change on falling edges.
`timescale 1ns/100ps
module tb;
  typedef struct {string nm; logic [2:0] ex;} fpl_note_t;
  logic clock = 0, rst = 1, honour = 1, sleep = 0, clr = 0;
  logic powerButton = 0, resetButton = 0, identifyButton = 0;
  logic chipsetWake = 0, acpiEnabled = 1, firmwareAck = 0;
  logic identifyCmdValid = 0, identifyCmdOn = 0;
  logic [12:0] flt = '0;
  logic [1:0] hotSwapSeverity = '0, firmwareSeverity = '0;
  logic [1:0] chipsetAcpiState;
  logic supplyPowerGood, powerButtonReq, resetButtonReq, supply_power_on;
  logic platformPowerGood, platformReset, powerLed, identifyLed;
  logic statusGreenLed, statusAmberLed;
  logic [2:0] powerState;
  logic [6:0] lv;
  int n_mismatch = 0, n_compared = 0, seed;
  int cnt [7];
  fpl_note_t q[$];
  event chk;
  always #10 clock = ~clock;
  fpl_front_panel #(.FAILSAFE_CYCLES(50), .PWROK_CYCLES(4),
    .RESET_CYCLES(4), .BLINK_CYCLES(8)) dut_u (.clock, .rst,
    .powerButton, .resetButton, .identifyButton, .chipsetWake,
    .chipsetAcpiState, .acpiEnabled, .firmwareAck, .powerButtonReq,
    .resetButtonReq, .supplyPowerGood, .supply_power_on,
    .platformPowerGood, .platformReset, .identifyCmdValid,
    .identifyCmdOn, .redundancyLost(flt[0]), .cpuDisabled(flt[1]),
    .fanFailed(flt[2]), .nonCriticalCrossed(flt[3]),
    .batteryFailed(flt[4]), .supplyPredictive(flt[5]),
    .criticalCrossed(flt[6]), .regulator_hot(flt[7]),
    .fansBelowMinimum(flt[8]), .cpu_catastrophic_error(flt[9]),
    .cpu_thermal_trip(flt[10]), .cpu1Missing(flt[11]),
    .supplyCountLow(flt[12]), .hotSwapSeverity, .firmwareSeverity,
    .powerLed, .identifyLed, .statusGreenLed, .statusAmberLed,
    .powerState);
  fpl_chipset_model model_u (.clock, .rst, .honour, .sleep,
    .supply_power_on, .powerButtonReq, .supplyPowerGood,
    .chipsetAcpiState);
  // Lit cycles and request pulses counted over a window
  assign lv = {1'b1, resetButtonReq, powerButtonReq, identifyLed,
    powerLed, statusAmberLed, statusGreenLed};
  always @(posedge clock)
  begin
    foreach (cnt[i])
      cnt[i] = clr ? 0 : cnt[i] + int'(lv[i]);
  end
  // LED class: 0 solid green, 1 green blink, 2 amber blink, 3 amber, 4 off
  function automatic logic [2:0] cls(int hi, int lo);
    if (hi == cnt[6])
      return 3'h3;
    if (hi > 0)
      return 3'h2;
    if (lo == cnt[6])
      return 3'h0;
    return (lo > 0) ? 3'h1 : 3'h4;
  endfunction : cls
  // Take each note off the queue and compare with what is seen
  always @(chk)
  begin
    while (q.size() > 0)
    begin
      fpl_note_t n;
      logic [2:0] v;
      n = q.pop_front();
      case (n.nm)
        "state": v = powerState;
        "supply": v = {2'h0, supply_power_on};
        "pgood": v = {2'h0, platformPowerGood};
        "reset": v = {2'h0, platformReset};
        "status": v = cls(cnt[1], cnt[0]);
        "power": v = cls(0, cnt[2]);
        "id": v = cls(0, cnt[3]);
        "preq": v = 3'(cnt[4]);
        default: v = 3'(cnt[5]);
      endcase
      n_compared++;
      if (v !== n.ex)
      begin
        n_mismatch++;
        $display("unexpected %s: expected %0d seen %0d", n.nm, n.ex, v);
      end
    end
  end
  task automatic cyc(int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  task automatic note(string nm, logic [2:0] ex);
    q.push_back('{nm, ex});
    -> chk;
  endtask : note
  task automatic clear();
    clr = 1;
    cyc(1);
    clr = 0;
  endtask : clear
  task automatic win();
    clear();
    cyc(24);
  endtask : win
  task automatic press(ref logic b);
    b = 1;
    cyc(2);
    b = 0;
    cyc(2);
  endtask : press
  task automatic cmd(logic on);
    identifyCmdOn = on;
    identifyCmdValid = 1;
    cyc(1);
    identifyCmdValid = 0;
    cyc(3);
  endtask : cmd
  task automatic waitSt(logic [2:0] s, int lim);
    int k = 0;
    while (powerState !== s && k < lim)
    begin
      cyc(1);
      k++;
    end
    if (powerState !== s)
    begin
      n_mismatch++;
      $display("unexpected powerState: expected %0d seen %0d", s, powerState);
      end_of_test();
    end
  endtask : waitSt
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Main sequence of tests
  initial
  begin
    seed = $urandom(32'h0000_c155);
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 0;
    note("state", 3'h0);
    note("reset", 3'h1);
    note("supply", 3'h0);
    $display("test reset done");
    press(powerButton);
    waitSt(3'h3, 40);
    note("pgood", 3'h1);
    note("reset", 3'h0);
    $display("test power-up done");
    win();
    note("power", 3'h0);
    sleep = 1;
    cyc(3);
    win();
    note("power", 3'h1);
    {sleep, acpiEnabled} = 2'b00;
    cyc(3);
    win();
    note("power", 3'h0);
    acpiEnabled = 1;
    $display("test power LED done");
    clear();
    press(resetButton);
    press(resetButton);
    note("rreq", 3'h2);
    note("preq", 3'h0);
    $display("test reset button done");
    for (int i = 0; i < 13; i++)
    begin
      flt = 13'h0001 << i;
      flt[$urandom_range(5, 0)] = 1'b1;
      cyc(3);
      win();
      note("status", i < 6 ? 3'h1 : i < 9 ? 3'h2 : 3'h3);
    end
    flt = '0;
    for (int s = 1; s < 4; s++)
    begin
      hotSwapSeverity = 2'(s);
      firmwareSeverity = 2'(s - 1);
      cyc(3);
      win();
      note("status", 3'(s));
    end
    hotSwapSeverity = '0;
    cyc(3);
    win();
    note("status", 3'h2);
    firmwareSeverity = '0;
    cyc(3);
    win();
    note("status", 3'h0);
    $display("test status LED done");
    press(identifyButton);
    win();
    note("id", 3'h0);
    win();
    note("id", 3'h0);
    cmd(1'b1);
    win();
    note("id", 3'h1);
    press(identifyButton);
    win();
    note("id", 3'h0);
    press(identifyButton);
    win();
    note("id", 3'h4);
    cmd(1'b1);
    cmd(1'b0);
    win();
    note("id", 3'h4);
    $display("test identify done");
    {honour, firmwareAck} = 2'b01;
    clear();
    press(powerButton);
    cyc(70);
    note("state", 3'h3);
    note("preq", 3'h1);
    firmwareAck = 0;
    press(powerButton);
    waitSt(3'h4, 70);
    waitSt(3'h0, 20);
    note("supply", 3'h0);
    $display("test fail-safe done");
    chipsetWake = 1;
    cyc(2);
    chipsetWake = 0;
    waitSt(3'h3, 40);
    flt[10] = 1'b1;
    honour = 1;
    cyc(3);
    press(powerButton);
    waitSt(3'h0, 20);
    win();
    note("status", 3'h4);
    note("power", 3'h4);
    $display("test power-off done");
    end_of_test();
  end
endmodule : tb
bind fpl_front_panel fpl_front_panel_properties
  #(.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) chk_u (.clock, .rst, .powerButton,
  .resetButton, .chipsetWake, .acpiEnabled, .cpu_catastrophic_error,
  .chipsetAcpiState, .powerButtonReq, .resetButtonReq, .supply_power_on,
  .platformPowerGood, .platformReset, .powerLed, .statusGreenLed,
  .statusAmberLed, .powerState);
